// [owd_pkg.sv]
// Package: offsets, field positions, reset values and carrier types for the option decoder
package owd_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_LSS_CTRL  = 12'h000;  // low_supply_status_control
  localparam logic [11:0] OFS_LSS_LEVEL = 12'h004;  // Detector enable and level
  localparam logic [11:0] OFS_OPT_VIEW  = 12'h008;  // Decoded clock setup, read only

  // ----------------------------------------------------------------
  // Option word field positions
  // ----------------------------------------------------------------
  localparam int W1_POWER_BIT  = 12;
  localparam int W1_TRIM_HI    = 11;
  localparam int W1_TRIM_LO    = 7;
  localparam int W1_IRC_HI     = 6;
  localparam int W1_IRC_LO     = 5;
  localparam int W1_OSC_HI     = 4;
  localparam int W1_OSC_LO     = 1;
  localparam int W1_CLKOUT_BIT = 0;
  localparam int W2_TOP_BIT    = 12;
  localparam int W2_GREEN_BIT  = 11;
  localparam int W2_PKG_BIT    = 10;
  localparam int W2_ID_HI      = 9;
  localparam int W0_BOR_HI     = 9;
  localparam int W0_BOR_LO     = 8;

  // ----------------------------------------------------------------
  // Detector register bit positions
  // ----------------------------------------------------------------
  localparam int CTRL_OK_N_BIT  = 7;
  localparam int CTRL_FLAG_BIT  = 6;
  localparam int CTRL_WAKE_BIT  = 0;
  localparam int LEVEL_EN_BIT   = 6;
  localparam int LEVEL_SEL_HI   = 5;
  localparam int LEVEL_SEL_LO   = 4;

  // Reset values
  localparam logic [1:0] LEVEL_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OWD_OSC_EXTRC_IO  = 4'h0,
    OWD_OSC_EXTRC_CLK = 4'h1,
    OWD_OSC_IRC_IO   = 4'h2,
    OWD_OSC_IRC_CLK  = 4'h3,
    OWD_OSC_LXT_A    = 4'h4,
    OWD_OSC_HXT_A    = 4'h5,
    OWD_OSC_LXT_B    = 4'h6,
    OWD_OSC_HXT_B    = 4'h7,
    OWD_OSC_MID      = 4'hF
  } owd_osc_e;

  typedef enum logic [1:0] {
    OWD_IRC_1MHZ  = 2'h0,
    OWD_IRC_8MHZ  = 2'h1,
    OWD_IRC_16MHZ = 2'h2,
    OWD_IRC_4MHZ  = 2'h3
  } owd_irc_e;

  // Brown-out thresholds in tenths of a volt, zero means power-on reset only
  localparam logic [5:0] BOR_RESET_11 = 6'h00;
  localparam logic [5:0] BOR_RESET_10 = 6'h1B;  // 2.7 V
  localparam logic [5:0] BOR_RESET_01 = 6'h23;  // 3.5 V
  localparam logic [5:0] BOR_RESET_00 = 6'h28;  // 4.0 V
  localparam logic [5:0] BOR_REL_10   = 6'h1D;  // 2.9 V
  localparam logic [5:0] BOR_REL_01   = 6'h25;  // 3.7 V
  localparam logic [5:0] BOR_REL_00   = 6'h2A;  // 4.2 V
  // Detector thresholds in tenths of a volt
  localparam logic [5:0] LSD_LVL_11   = 6'h16;  // 2.2 V
  localparam logic [5:0] LSD_LVL_10   = 6'h21;  // 3.3 V
  localparam logic [5:0] LSD_LVL_01   = 6'h28;  // 4.0 V
  localparam logic [5:0] LSD_LVL_00   = 6'h2D;  // 4.5 V

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       low_power;     // Low-power operation
    logic [1:0] irc_freq;      // owd_irc_e code
    logic [3:0] osc_mode;      // Effective owd_osc_e code
    logic       xtal_pins;     // Both oscillator pins owned by the oscillator
    logic       alt_io_gpio;   // Alternate pin is plain I/O
    logic       rc_input_use;  // RC input pin is the oscillator
    logic       clkout_en;     // Shared pin acts as clock output
    logic       clkout_od;     // Clock output is open drain
    logic       green_16k;     // Green clock 16 kHz when set, 128 kHz when clear
    logic       pkg_20pin;     // 20-pin variant when set
    logic [9:0] customer_id;
  } owd_clk_cfg_s;

  typedef struct packed {
    logic [5:0] reset_level;   // Tenths of a volt, zero for none
    logic [5:0] release_level;
    logic [5:0] detect_level;
  } owd_volt_cfg_s;

  typedef struct packed {
    logic       ok_sync1;
    logic       ok_sync2;
    logic       ok_sync3;
    logic       flag;
    logic       wake_en;
    logic       detect_en;
    logic [1:0] level_sel;
    logic [31:0] prdata;
  } owd_state_s;

endpackage

// [owd_top.sv]
// Option word decoder and low-supply detector register block
// Overview of operation
// [R01] Word one bit 12: zero low-power up to 400kHz, one high-power.
// [R02] Programmer leaves the five RC trim bits all ones.
// [R03] RC frequency field: 11 4MHz, 10 16MHz, 01 8MHz, 00 1MHz.
// [R04] Oscillator codes 0000-0011: external or internal RC, pin as I/O or clock.
// [R05] Codes 0100-0111 select crystal modes; 1111 is mid-range crystal.
// [R06] Every crystal mode dedicates both oscillator pins, never general I/O.
// [R07] Internal RC mode makes the alternate pin ordinary I/O.
// [R08] External RC mode uses the RC input pin as oscillator.
// [R09] In RC clock-out modes bit 0 picks open drain or clock drive.
// [R10] Programmer always sets word two bit 12 to one.
// [R11] Word two bit 11 picks green clock: zero 128kHz, one 16kHz.
// [R12] Word two bit 10 picks package: zero 18-pin, one 20-pin.
// [R13] Word two bits 9-0 carry a customer ID with no effect.
// [R14] Word zero bits 9-8 select brown-out reset and release levels.
// [R15] Status bit 7 reads zero while supply is low, else one.
// [R16] Flag bit 6 marks a pending detector request; software or hardware clears it.
// [R17] Bit 0 is a software read/write low-supply wake enable.
// [R18] Software sets wake enable whenever detection must interrupt or wake.
// [R19] Register contents are kept while supply falls below operating voltage.
// [R20] Level field selects 2.2, 3.3, 4.0 or 4.5V; disabled reads status one.
// [R21] Separate enable bit turns the detector on or off.
// [R22] System reset clears the low-supply flag.
// [R23] Option bits are fixed inputs, not reachable by the program.
// [R24] Unlisted oscillator codes fall back to mid-range crystal.
// [R25] Control bits 5 to 1 read zero and ignore writes.
`timescale 1ns/100ps

module owd_top (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [12:0]          option_word0,
  input  wire logic [12:0]          option_word1,
  input  wire logic [12:0]          option_word2,
  input  wire logic                 supply_below_level,
  input  wire logic                 hw_flag_clear,
  output owd_pkg::owd_clk_cfg_s     clk_cfg,
  output owd_pkg::owd_volt_cfg_s    volt_cfg,
  output logic                      low_supply_flag,
  output logic                      low_supply_wake_en,
  output logic                      low_supply_wake
);

  // ----------------------------------------------------------------
  // Option word decode
  // ----------------------------------------------------------------
  owd_pkg::owd_state_s   st;
  owd_pkg::owd_state_s   next_st;
  owd_pkg::owd_clk_cfg_s next_clk_cfg;
  owd_pkg::owd_volt_cfg_s next_volt_cfg;
  logic [3:0]            osc_raw;
  logic                  is_ext_rc;
  logic                  is_irc;
  logic                  is_xtal;

  // Option words are straps with no software path; decode stays purely combinational
  assign osc_raw = option_word1[owd_pkg::W1_OSC_HI:owd_pkg::W1_OSC_LO];  // [R23]

  // Oscillator mode and pin ownership
  always_comb begin
    next_clk_cfg = '0;
    next_clk_cfg.low_power = ~option_word1[owd_pkg::W1_POWER_BIT];  // [R01]
    next_clk_cfg.irc_freq  = option_word1[owd_pkg::W1_IRC_HI:owd_pkg::W1_IRC_LO];  // [R03]
    case (osc_raw)
      owd_pkg::OWD_OSC_EXTRC_IO, owd_pkg::OWD_OSC_EXTRC_CLK, owd_pkg::OWD_OSC_IRC_IO, owd_pkg::OWD_OSC_IRC_CLK,
      owd_pkg::OWD_OSC_LXT_A, owd_pkg::OWD_OSC_HXT_A, owd_pkg::OWD_OSC_LXT_B, owd_pkg::OWD_OSC_HXT_B,
      owd_pkg::OWD_OSC_MID: begin
        next_clk_cfg.osc_mode = osc_raw;  // [R04] [R05]
      end
      default: begin
        next_clk_cfg.osc_mode = owd_pkg::OWD_OSC_MID;  // [R24]
      end
    endcase
    is_ext_rc = (next_clk_cfg.osc_mode == owd_pkg::OWD_OSC_EXTRC_IO) ||
                (next_clk_cfg.osc_mode == owd_pkg::OWD_OSC_EXTRC_CLK);
    is_irc    = (next_clk_cfg.osc_mode == owd_pkg::OWD_OSC_IRC_IO) ||
                (next_clk_cfg.osc_mode == owd_pkg::OWD_OSC_IRC_CLK);
    is_xtal   = ~is_ext_rc & ~is_irc;
    next_clk_cfg.xtal_pins    = is_xtal;  // [R06]
    next_clk_cfg.alt_io_gpio  = is_irc;  // [R07]
    next_clk_cfg.rc_input_use = is_ext_rc;  // [R08]
    next_clk_cfg.clkout_en    = (is_ext_rc | is_irc) & next_clk_cfg.osc_mode[0];
    next_clk_cfg.clkout_od    = next_clk_cfg.clkout_en & ~option_word1[owd_pkg::W1_CLKOUT_BIT];  // [R09]
    next_clk_cfg.green_16k    = option_word2[owd_pkg::W2_GREEN_BIT];  // [R11]
    next_clk_cfg.pkg_20pin    = option_word2[owd_pkg::W2_PKG_BIT];  // [R12]
    next_clk_cfg.customer_id  = option_word2[owd_pkg::W2_ID_HI:0];  // [R13]
  end

  assign clk_cfg = next_clk_cfg;

  // Brown-out and detector thresholds
  always_comb begin
    next_volt_cfg = '0;
    case (option_word0[owd_pkg::W0_BOR_HI:owd_pkg::W0_BOR_LO])
      2'h3: begin
        next_volt_cfg.reset_level   = owd_pkg::BOR_RESET_11;  // [R14]
        next_volt_cfg.release_level = owd_pkg::BOR_RESET_11;
      end
      2'h2: begin
        next_volt_cfg.reset_level   = owd_pkg::BOR_RESET_10;
        next_volt_cfg.release_level = owd_pkg::BOR_REL_10;
      end
      2'h1: begin
        next_volt_cfg.reset_level   = owd_pkg::BOR_RESET_01;
        next_volt_cfg.release_level = owd_pkg::BOR_REL_01;
      end
      default: begin
        next_volt_cfg.reset_level   = owd_pkg::BOR_RESET_00;
        next_volt_cfg.release_level = owd_pkg::BOR_REL_00;
      end
    endcase
    case (st.level_sel)
      2'h3: next_volt_cfg.detect_level = owd_pkg::LSD_LVL_11;  // [R20]
      2'h2: next_volt_cfg.detect_level = owd_pkg::LSD_LVL_10;
      2'h1: next_volt_cfg.detect_level = owd_pkg::LSD_LVL_01;
      default: next_volt_cfg.detect_level = owd_pkg::LSD_LVL_00;
    endcase
  end

  assign volt_cfg = next_volt_cfg;

  // ----------------------------------------------------------------
  // Detector registers and APB slave
  // ----------------------------------------------------------------
  logic       wr_en;
  logic       rd_en;
  logic       supply_low;
  logic       low_seen;
  logic       flag_set;
  logic [7:0] ctrl_view;
  logic [7:0] level_view;
  logic [7:0] opt_view;
  logic       addr_ok;

  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & ~penable & ~pwrite;
  assign addr_ok = (paddr == owd_pkg::OFS_LSS_CTRL) || (paddr == owd_pkg::OFS_LSS_LEVEL) ||
                   (paddr == owd_pkg::OFS_OPT_VIEW);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  // Low seen only after the second and third stage agree; the detector off hides it
  assign low_seen   = st.ok_sync2 & st.ok_sync3;
  assign supply_low = st.detect_en & low_seen;  // [R15] [R20]
  assign flag_set   = supply_low;  // Level sensitive: re-arms each cycle while supply stays low

  // Views of each register for readback
  assign ctrl_view  = {~supply_low, st.flag, 5'h00, st.wake_en};  // [R15] [R25]
  assign level_view = {1'b0, st.detect_en, st.level_sel, 4'h0};
  assign opt_view   = {next_clk_cfg.osc_mode, next_clk_cfg.irc_freq, next_clk_cfg.pkg_20pin, next_clk_cfg.green_16k};

  // Next-state logic; the register file only changes on clock edges, so a dip in
  // supply that the core survives leaves its contents alone
  always_comb begin
    next_st = st;  // [R19]
    next_st.ok_sync1 = supply_below_level;
    next_st.ok_sync2 = st.ok_sync1;
    next_st.ok_sync3 = st.ok_sync2;
    if (wr_en && (paddr == owd_pkg::OFS_LSS_CTRL) && pstrb[0]) begin
      next_st.wake_en = pwdata[owd_pkg::CTRL_WAKE_BIT];  // [R17]
      if (!pwdata[owd_pkg::CTRL_FLAG_BIT]) begin
        next_st.flag = 1'b0;  // [R16]
      end
    end
    if (wr_en && (paddr == owd_pkg::OFS_LSS_LEVEL) && pstrb[0]) begin
      next_st.detect_en = pwdata[owd_pkg::LEVEL_EN_BIT];  // [R21]
      next_st.level_sel = pwdata[owd_pkg::LEVEL_SEL_HI:owd_pkg::LEVEL_SEL_LO];
    end
    if (hw_flag_clear) begin
      next_st.flag = 1'b0;  // [R16]
    end
    // A new low event outranks any clear in the same cycle
    if (flag_set) begin
      next_st.flag = 1'b1;  // [R16]
    end
    if (rd_en) begin
      if (paddr == owd_pkg::OFS_LSS_CTRL) begin
        next_st.prdata = {24'h00_0000, ctrl_view};
      end else if (paddr == owd_pkg::OFS_LSS_LEVEL) begin
        next_st.prdata = {24'h00_0000, level_view};
      end else if (paddr == owd_pkg::OFS_OPT_VIEW) begin
        next_st.prdata = {24'h00_0000, opt_view};
      end else begin
        next_st.prdata = 32'h0000_0000;
      end
    end
  end

  // State register; reset clears the flag and every control bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;  // [R22]
    end else begin
      st <= next_st;
    end
  end

  assign prdata             = st.prdata;
  assign low_supply_flag    = st.flag;
  assign low_supply_wake_en = st.wake_en;
  assign low_supply_wake    = st.flag & st.wake_en;  // [R18]

endmodule

// [owd_props.sv]
// Port-level properties of the option decoder and low-supply register block
`timescale 1ns/100ps
module owd_props (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [11:0]            paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [3:0]             pstrb,
  input wire logic [31:0]            prdata,
  input wire logic [12:0]            option_word0,
  input wire logic [12:0]            option_word1,
  input wire logic                   supply_below_level,
  input wire logic                   hw_flag_clear,
  input wire owd_pkg::owd_clk_cfg_s  clk_cfg,
  input wire owd_pkg::owd_volt_cfg_s volt_cfg,
  input wire logic                   low_supply_flag,
  input wire logic                   low_supply_wake_en,
  input wire logic                   low_supply_wake
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic [4:0] low_hist;  // Recent supply samples, wide enough for the synchroniser delay

  // Shift history so a flag rise can be traced to a low supply
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_hist <= 5'h00;
    end else begin
      low_hist <= {low_hist[3:0], supply_below_level};
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence ctrl_rd_s;
    psel && penable && !pwrite && paddr == 12'h000;
  endsequence
  sequence flag_keep_s;
    low_supply_flag && !hw_flag_clear && !(psel && penable && pwrite && paddr == 12'h000 && pstrb[0] && !pwdata[6]);
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  low_power_a: assert property (clk_cfg.low_power == !option_word1[12])
    else $error("power mode decode wrong");
  osc_reserved_a: assert property (option_word1[4:1] inside {[4'h8:4'hE]} |-> clk_cfg.osc_mode == 4'hF)
    else $error("reserved oscillator code not mapped to mid crystal");
  xtal_pins_a: assert property (clk_cfg.xtal_pins == (option_word1[4:1] >= 4'h4))
    else $error("crystal pin ownership wrong");
  irc_io_a: assert property (clk_cfg.alt_io_gpio == (option_word1[4:2] == 3'h1))
    else $error("alternate pin function wrong");
  ext_rc_pin_a: assert property (clk_cfg.rc_input_use == (option_word1[4:1] < 4'h2))
    else $error("rc input pin use wrong");
  bor_level_a: assert property (volt_cfg.reset_level == (option_word0[9:8] == 2'h3 ? 6'h00 :
    option_word0[9:8] == 2'h2 ? 6'h1B : option_word0[9:8] == 2'h1 ? 6'h23 : 6'h28))
    else $error("brown-out reset level wrong");
  ctrl_read_a: assert property (ctrl_rd_s |-> prdata[5:1] == 5'h00 && prdata[31:8] == 24'h00_0000)
    else $error("unused control bits not zero");
  wake_out_a: assert property (low_supply_wake == (low_supply_flag && low_supply_wake_en))
    else $error("wake output mismatch");
  flag_rise_a: assert property ($rose(low_supply_flag) |-> low_hist != 5'h00)
    else $error("flag rose without low supply");
  flag_hold_a: assert property (flag_keep_s |=> low_supply_flag)
    else $error("flag dropped without a clear");
  flag_reset_a: assert property (disable iff (1'b0) !presetn |-> !low_supply_flag)
    else $error("flag not cleared by reset");
endmodule

bind owd_top owd_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .option_word0(option_word0),
  .option_word1(option_word1), .supply_below_level(supply_below_level), .hw_flag_clear(hw_flag_clear),
  .clk_cfg(clk_cfg), .volt_cfg(volt_cfg), .low_supply_flag(low_supply_flag),
  .low_supply_wake_en(low_supply_wake_en), .low_supply_wake(low_supply_wake));

// [testbench.sv]
// Self-checking bench for the option decoder and low-supply register block
`timescale 1ns/100ps
module testbench;
  logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic                   sbl, hw_clr, flag, wake_en, wake, ce;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata, r;
  logic [3:0]             pstrb;
  logic [12:0]            w0, w1, w2;
  owd_pkg::owd_clk_cfg_s  clk_cfg;
  owd_pkg::owd_volt_cfg_s volt_cfg;
  int                     miscompares, cmp_count, seed;
  logic [32:0]            exp_q[$];
  logic [5:0]             lvl_tab[4] = '{6'h2D, 6'h28, 6'h21, 6'h16};

  owd_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .option_word0(w0),
    .option_word1(w1), .option_word2(w2), .supply_below_level(sbl), .hw_flag_clear(hw_clr), .clk_cfg(clk_cfg),
    .volt_cfg(volt_cfg), .low_supply_flag(flag), .low_supply_wake_en(wake_en), .low_supply_wake(wake));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  function automatic logic [3:0] osc_exp(input logic [3:0] c);
    return (c <= 4'h7 || c == 4'hF) ? c : 4'hF;
  endfunction

  // Release level of the power-on-only code is taken as zero
  function automatic logic [11:0] bor_exp(input logic [1:0] c);
    case (c)
      2'h3: return 12'h000;
      2'h2: return {6'h1B, 6'h1D};
      2'h1: return {6'h23, 6'h25};
      default: return {6'h28, 6'h2A};
    endcase
  endfunction

  task automatic finish_test();
    $display("compares %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Read data and error flag are judged at the access edge against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      chk({pslverr, prdata}, exp_q.pop_front());
    end
    // Writes to a hole answer at once and flag an error
    if (psel && penable && pwrite && paddr == 12'h00C) begin
      chk({pready, pslverr}, 2'b11);
    end
  end

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    finish_test();
  end

  initial begin
    seed = 32'hb2ef_0060;
    // Start high and fall at once so the asynchronous reset sees a real edge
    {presetn, psel, penable, pwrite, sbl, hw_clr} = 6'h20;
    presetn <= 1'b0;
    {paddr, pwdata, pstrb} = {12'h000, 32'h0000_0000, 4'hF};
    {w0, w1, w2} = {13'h1FFF, 13'h1FFF, 13'h1FFF};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      ce = (i == 1 || i == 3);
      w0 <= r[25:13];
      w1 <= {r[12], 5'h1F, r[6:5], i[3:0], r[0]};
      w2 <= {1'b1, r[11:0]};
      @(posedge pclk);
      chk(clk_cfg.osc_mode, osc_exp(i[3:0]));
      chk({clk_cfg.xtal_pins, clk_cfg.alt_io_gpio, clk_cfg.rc_input_use}, {i >= 4, i == 2 || i == 3, i < 2});
      chk({clk_cfg.clkout_en, clk_cfg.clkout_en && clk_cfg.clkout_od}, {ce, ce && !w1[0]});
      chk({clk_cfg.low_power, clk_cfg.irc_freq}, {!w1[12], w1[6:5]});
      chk({clk_cfg.green_16k, clk_cfg.pkg_20pin, clk_cfg.customer_id}, w2[11:0]);
      chk({volt_cfg.reset_level, volt_cfg.release_level}, bor_exp(w0[9:8]));
      rd(12'h008, {25'h000_0000, osc_exp(i[3:0]), w1[6:5], w2[10], w2[11]});
    end
    $display("option decode test done");
    rd(12'h000, 33'h0_0000_0080);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, 12'h004, {25'h000_0000, 1'b1, c[1:0], 4'h0});
      rd(12'h004, {26'h000_0001, c[1:0], 4'h0});
      chk(volt_cfg.detect_level, lvl_tab[c]);
    end
    $display("detector level test done");
    apb(1'b1, 12'h000, 32'h0000_0001);
    sbl <= 1'b1;
    repeat (6) @(posedge pclk);
    rd(12'h000, 33'h0_0000_0041);
    chk(wake, 1'b1);
    chk(wake_en, 1'b1);
    sbl <= 1'b0;
    repeat (6) @(posedge pclk);
    rd(12'h000, 33'h0_0000_00C1);
    apb(1'b1, 12'h000, 32'h0000_007F);
    rd(12'h000, 33'h0_0000_00C1);
    apb(1'b1, 12'h000, 32'h0000_0001);
    rd(12'h000, 33'h0_0000_0081);
    apb(1'b1, 12'h004, 32'h0000_0000);
    sbl <= 1'b1;
    repeat (6) @(posedge pclk);
    rd(12'h000, 33'h0_0000_0081);
    apb(1'b1, 12'h004, 32'h0000_0040);
    sbl <= 1'b0;
    repeat (6) @(posedge pclk);
    hw_clr <= 1'b1;
    @(posedge pclk);
    hw_clr <= 1'b0;
    rd(12'h000, 33'h0_0000_0081);
    apb(1'b1, 12'h00C, 32'h0000_0000);
    rd(12'h00C, 33'h1_0000_0000);
    rd(12'h000, 33'h0_0000_0081);
    $display("supply flag test done");
    sbl <= 1'b1;
    repeat (6) @(posedge pclk);
    presetn <= 1'b0;
    sbl <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(flag, 1'b0);
    presetn <= 1'b1;
    rd(12'h000, 33'h0_0000_0080);
    rd(12'h004, 33'h0_0000_0000);
    $display("reset test done");
    finish_test();
  end
endmodule
